// File: ccr_clk_res.sv
module ccr_clk_res (
	input wire logic i_clk, // pci clock
	input wire logic i_srst, // sync reset
	input wire logic i_dev_pull, // device pulls line low
	input wire logic i_run, // keep clock running
	input wire logic [2:0] i_hold, // edges held low, four or more
	output logic o_pull // resource pulls line low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_ff;
	// edges since the device's first assertion
	always_ff @(posedge i_clk) begin
		if (i_srst) cnt_ff <= 3'h0;
		else if (cnt_ff != 3'h0) cnt_ff <= (cnt_ff < i_hold) ? cnt_ff + 3'h1 : 3'h0;
		else if (i_dev_pull) cnt_ff <= 3'h1;
	end
	assign o_pull = i_run || cnt_ff != 3'h0;
endmodule

// File: ccr_pkg.sv
package ccr_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CTRL_STAT_ADDR = 8'h3C;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h40;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h44;
	localparam int STS_BIT = 15;
	localparam int EN_BIT = 8;
	localparam int CLKRUN_EN_BIT = 0;
	localparam logic [31:0] CTRL_STAT_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// interrupt status bits
	localparam int IRQ_CONT_BIT = 0;
	localparam int IRQ_START_BIT = 1;
	localparam int IRQ_WAKE_BIT = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// ----------------------------------------
	// timing counts (pci clock edges)
	// ----------------------------------------
	localparam logic [1:0] HOLD_EDGES = 2'h2;
	localparam logic [1:0] IDLE_EDGES = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DRIVE = 3'b010,
		ST_WAIT = 3'b100
	} ccr_state_t;

	typedef struct packed {
		logic tx_pending;
		logic rx_pending;
		logic rx_dma_ready;
		logic wake_packet;
	} ccr_work_t;
endpackage

// File: ccr_top.sv
// The AXI4-Lite slave port was left to the implementer.
module ccr_top (
	input wire logic I_CLK, // pci clock
	input wire logic I_SRST, // sync reset, high
	input wire logic I_HARD_RST, // hard reset: clears control bits
	input wire logic [31:0] I_AWADDR, // axi write address
	input wire logic I_AWVALID, // axi
	output logic O_AWREADY, // axi
	input wire logic [31:0] I_WDATA, // axi
	input wire logic [3:0] I_WSTRB, // axi
	input wire logic I_WVALID, // axi
	output logic O_WREADY, // axi
	output logic [1:0] O_BRESP, // axi
	output logic O_BVALID, // axi
	input wire logic I_BREADY, // axi
	input wire logic [31:0] I_ARADDR, // axi read address
	input wire logic I_ARVALID, // axi
	output logic O_ARREADY, // axi
	output logic [31:0] O_RDATA, // axi
	output logic [1:0] O_RRESP, // axi
	output logic O_RVALID, // axi
	input wire logic I_RREADY, // axi
	input wire logic I_CFG_WR, // config-space write of power mgmt csr
	input wire logic I_CFG_STS_W1C, // config write: clear status
	input wire logic I_CFG_EN, // config write: enable value
	output logic O_CFG_STS, // status mirror for config read
	output logic O_CFG_EN, // enable mirror for config read
	input wire logic I_EE_LOAD, // serial memory autoload strobe
	input wire logic I_EE_EN, // enable value from serial memory
	input wire ccr_pkg::ccr_work_t I_WORK, // pending work, pci clock domain
	input wire logic I_WAKE_EVT, // wake event pulse
	input wire logic I_LINE_IN, // shared pin level
	output logic O_LINE_OUT, // shared pin output value
	output logic O_LINE_OE, // shared pin output enable
	output logic O_RX_CLK_SEL, // 1: rx uses crystal reference
	output logic O_IRQ // level interrupt
);
	// ----------------------------------------
	// line synchroniser
	// ----------------------------------------
	logic line_s1_ff;
	logic line_s2_ff;
	always_ff @(posedge I_CLK) begin
		line_s1_ff <= I_LINE_IN;
		line_s2_ff <= line_s1_ff;
	end

	// ----------------------------------------
	// control / status bits
	// ----------------------------------------
	logic sts_ff, en_ff, clkrun_en_ff, aw_ok, w_ok, wr_fire;
	logic aw_held_ff, w_held_ff, set_sts, wr_ctrl, ctrl_clr;
	logic [31:0] aw_addr_ff, w_data_ff, wr_addr, wr_data;
	logic [3:0] w_strb_ff, wr_strb;
	logic [2:0] irq_sts_ff, irq_mask_ff, irq_set;

	assign wr_addr = aw_held_ff ? aw_addr_ff : I_AWADDR;
	assign wr_data = w_held_ff ? w_data_ff : I_WDATA;
	assign wr_strb = w_held_ff ? w_strb_ff : I_WSTRB;
	// a channel counts only once its ready took it, else a ghost write follows
	assign aw_ok = aw_held_ff | (I_AWVALID & O_AWREADY);
	assign w_ok = w_held_ff | (I_WVALID & O_WREADY);
	assign wr_fire = aw_ok & w_ok & ~O_BVALID;
	assign wr_ctrl = wr_fire & (wr_addr[7:0] == ccr_pkg::CTRL_STAT_ADDR);
	// soft reset leaves this register unchanged; only hard reset clears it
	assign ctrl_clr = I_HARD_RST;

	// outside clkrun mode wake events set status regardless of enable; in clkrun mode a request sets it, and requests need enable
	always_ff @(posedge I_CLK) begin
		if (ctrl_clr) begin
			sts_ff <= 1'b0;
		end else if (set_sts) begin
			sts_ff <= 1'b1;
		end else if ((wr_ctrl & wr_strb[1] & wr_data[ccr_pkg::STS_BIT])
				| (I_CFG_WR & I_CFG_STS_W1C)) begin
			sts_ff <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (ctrl_clr) begin
			en_ff <= 1'b0;
		end else if (I_EE_LOAD) begin
			en_ff <= I_EE_EN;
		end else if (wr_ctrl & wr_strb[1]) begin
			en_ff <= wr_data[ccr_pkg::EN_BIT];
		end else if (I_CFG_WR) begin
			en_ff <= I_CFG_EN;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (ctrl_clr) begin
			clkrun_en_ff <= 1'b0;
		end else if (wr_ctrl & wr_strb[0]) begin
			clkrun_en_ff <= wr_data[ccr_pkg::CLKRUN_EN_BIT];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_CFG_STS <= 1'b0;
			O_CFG_EN <= 1'b0;
		end else begin
			O_CFG_STS <= sts_ff;
			O_CFG_EN <= en_ff;
		end
	end

	// ----------------------------------------
	// clock-run sequencer
	// ----------------------------------------
	ccr_pkg::ccr_state_t state_ff;
	ccr_pkg::ccr_state_t nxt_state;
	logic [1:0] edge_cnt_ff, nxt_edge_cnt, idle_cnt_ff;
	logic need_cont, need_start, line_high, start_ok, is_start_ff;

	assign line_high = line_s2_ff;
	// continue: system wants to stop but transfer still pending
	assign need_cont = I_WORK.tx_pending | I_WORK.rx_pending;
	// start: clock stopped, bus needed for dma or wake
	assign need_start = I_WORK.rx_dma_ready | I_WORK.wake_packet;
	// clkrun mode and enable set; cleared enable forbids requests
	assign start_ok = clkrun_en_ff & en_ff & (idle_cnt_ff == ccr_pkg::IDLE_EDGES)
		& (need_cont | need_start);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			idle_cnt_ff <= 2'h0;
		end else if (!line_high || state_ff != ccr_pkg::ST_IDLE) begin
			idle_cnt_ff <= 2'h0;
		end else if (idle_cnt_ff != ccr_pkg::IDLE_EDGES) begin
			idle_cnt_ff <= idle_cnt_ff + 2'h1;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_edge_cnt = edge_cnt_ff;
		case (state_ff)
			ccr_pkg::ST_IDLE: begin
				nxt_edge_cnt = 2'h0;
				if (start_ok) begin
					nxt_state = ccr_pkg::ST_DRIVE;
				end
			end
			ccr_pkg::ST_DRIVE: begin
				nxt_edge_cnt = edge_cnt_ff + 2'h1;
				if (edge_cnt_ff + 2'h1 == ccr_pkg::HOLD_EDGES) begin
					nxt_state = ccr_pkg::ST_WAIT;
				end
			end
			ccr_pkg::ST_WAIT: begin
				// finished event holds nothing: back to idle once line freed
				if (line_high) begin
					nxt_state = ccr_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = ccr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			state_ff <= ccr_pkg::ST_IDLE;
			edge_cnt_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			edge_cnt_ff <= nxt_edge_cnt;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			is_start_ff <= 1'b0;
		end else if (state_ff == ccr_pkg::ST_IDLE && start_ok) begin
			is_start_ff <= ~need_cont;
		end
	end

	assign set_sts = (I_WAKE_EVT & ~clkrun_en_ff)
		| (state_ff == ccr_pkg::ST_IDLE & start_ok);

	// ----------------------------------------
	// shared pin drive
	// ----------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_LINE_OUT <= 1'b0;
			O_LINE_OE <= 1'b0;
		end else begin
			O_LINE_OUT <= 1'b0;
			if (clkrun_en_ff) begin
				O_LINE_OE <= (nxt_state == ccr_pkg::ST_DRIVE) & en_ff;
			end else begin
				O_LINE_OE <= sts_ff & en_ff;
			end
		end
	end

	// in clkrun mode rx clock follows line: low means pci clock running
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_RX_CLK_SEL <= 1'b0;
		end else begin
			O_RX_CLK_SEL <= clkrun_en_ff & line_high;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic wr_isr;
	logic wr_imr;
	assign wr_isr = wr_fire & (wr_addr[7:0] == ccr_pkg::IRQ_STAT_ADDR) & wr_strb[0];
	assign wr_imr = wr_fire & (wr_addr[7:0] == ccr_pkg::IRQ_MASK_ADDR) & wr_strb[0];
	assign irq_set[ccr_pkg::IRQ_CONT_BIT] = (state_ff == ccr_pkg::ST_DRIVE)
		& (nxt_state == ccr_pkg::ST_WAIT) & ~is_start_ff;
	assign irq_set[ccr_pkg::IRQ_START_BIT] = (state_ff == ccr_pkg::ST_DRIVE)
		& (nxt_state == ccr_pkg::ST_WAIT) & is_start_ff;
	assign irq_set[ccr_pkg::IRQ_WAKE_BIT] = I_WAKE_EVT;

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			irq_sts_ff <= ccr_pkg::IRQ_RST;
		end else begin
			// a new event wins over the clearing write
			irq_sts_ff <= (irq_sts_ff & ~(wr_isr ? wr_data[2:0] : 3'h0)) | irq_set;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			irq_mask_ff <= ccr_pkg::IRQ_RST;
		end else if (wr_imr) begin
			irq_mask_ff <= wr_data[2:0];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_sts_ff & irq_mask_ff);
		end
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	logic wr_known;
	assign wr_known = (wr_addr[7:0] == ccr_pkg::CTRL_STAT_ADDR)
		| (wr_addr[7:0] == ccr_pkg::IRQ_STAT_ADDR)
		| (wr_addr[7:0] == ccr_pkg::IRQ_MASK_ADDR);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 32'h0000_0000;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			O_BVALID <= 1'b0;
			O_BRESP <= ccr_pkg::RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= wr_known ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
			end else begin
				if (I_AWVALID & O_AWREADY) begin
					aw_held_ff <= 1'b1;
					aw_addr_ff <= I_AWADDR;
				end
				if (I_WVALID & O_WREADY) begin
					w_held_ff <= 1'b1;
					w_data_ff <= I_WDATA;
					w_strb_ff <= I_WSTRB;
				end
				if (O_BVALID & I_BREADY) begin
					O_BVALID <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
		end else begin
			O_AWREADY <= ~aw_held_ff & ~O_BVALID & ~(I_AWVALID & O_AWREADY);
			O_WREADY <= ~w_held_ff & ~O_BVALID & ~(I_WVALID & O_WREADY);
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	logic [31:0] rd_word;
	logic rd_known;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_known = 1'b1;
		case (I_ARADDR[7:0])
			ccr_pkg::CTRL_STAT_ADDR: begin
				rd_word[ccr_pkg::STS_BIT] = sts_ff;
				rd_word[ccr_pkg::EN_BIT] = en_ff;
				rd_word[ccr_pkg::CLKRUN_EN_BIT] = clkrun_en_ff;
			end
			ccr_pkg::IRQ_STAT_ADDR: begin
				rd_word[2:0] = irq_sts_ff;
			end
			ccr_pkg::IRQ_MASK_ADDR: begin
				rd_word[2:0] = irq_mask_ff;
			end
			default: begin
				rd_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= ccr_pkg::RESP_OKAY;
		end else if (I_ARVALID & O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= rd_word;
			O_RRESP <= rd_known ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
		end else if (O_RVALID) begin
			if (I_RREADY) begin
				O_RVALID <= 1'b0;
			end
		end else begin
			O_ARREADY <= 1'b1;
		end
	end
endmodule

// File: ccr_top_checker.sv
module ccr_top_checker (
	input wire logic I_CLK, // pci clock
	input wire logic I_SRST, // sync reset
	input wire logic I_HARD_RST, // hard reset
	input wire logic [31:0] I_AWADDR, // write address
	input wire logic I_AWVALID, // aw valid
	input wire logic O_AWREADY, // aw ready
	input wire logic [31:0] I_WDATA, // write data
	input wire logic I_WVALID, // w valid
	input wire logic O_WREADY, // w ready
	input wire logic O_BVALID, // b valid
	input wire logic I_CFG_WR, // config write
	input wire logic I_CFG_EN, // config enable value
	input wire logic O_CFG_STS, // status mirror
	input wire logic O_CFG_EN, // enable mirror
	input wire logic I_EE_LOAD, // autoload strobe
	input wire logic I_EE_EN, // autoload value
	input wire logic I_LINE_IN, // pin level
	input wire logic O_LINE_OUT, // pin value
	input wire logic O_LINE_OE // pin enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] aw_ff;
	logic w_ff;
	logic mode_ff;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST);
	always_ff @(posedge I_CLK) begin
		if (I_AWVALID && O_AWREADY) aw_ff <= I_AWADDR[7:0];
	end
	always_ff @(posedge I_CLK) begin
		if (I_WVALID && O_WREADY) w_ff <= I_WDATA[0];
	end
	// mode follows completed writes, so it lags the register by a cycle
	always_ff @(posedge I_CLK) begin
		if (I_HARD_RST) mode_ff <= 1'b0;
		else if ($rose(O_BVALID) && aw_ff == ccr_pkg::CTRL_STAT_ADDR) mode_ff <= w_ff;
	end
	chk_line_low: assert property (!O_LINE_OUT)
		else $error("line driven high");
	chk_pulse_two: assert property (mode_ff && $rose(O_LINE_OE) |=> O_LINE_OE ##1 !O_LINE_OE)
		else $error("request pulse not two cycles");
	chk_idle_two: assert property (mode_ff && $rose(O_LINE_OE)
		|-> $past(I_LINE_IN, 4) && $past(I_LINE_IN, 5))
		else $error("request without idle line");
	chk_en_gate: assert property ($rose(O_LINE_OE) |-> O_CFG_EN)
		else $error("pin asserted while disabled");
	chk_wake_level: assert property (!mode_ff && !$past(mode_ff, 3)
		|-> O_LINE_OE == (O_CFG_STS && O_CFG_EN))
		else $error("wake pin level wrong");
	chk_cfg_mirror: assert property (I_CFG_WR && !I_EE_LOAD && !I_AWVALID && !I_WVALID
		|-> ##2 O_CFG_EN == $past(I_CFG_EN, 2))
		else $error("config enable not mirrored");
	chk_ee_load: assert property (I_EE_LOAD |-> ##2 O_CFG_EN == $past(I_EE_EN, 2))
		else $error("autoload enable lost");
	chk_sts_set: assert property (mode_ff && $rose(O_LINE_OE) |=> O_CFG_STS)
		else $error("status not set by request");
endmodule

bind ccr_top ccr_top_checker u_chk (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_HARD_RST(I_HARD_RST),
	.I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA),
	.I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_CFG_WR(I_CFG_WR),
	.I_CFG_EN(I_CFG_EN), .O_CFG_STS(O_CFG_STS), .O_CFG_EN(O_CFG_EN), .I_EE_LOAD(I_EE_LOAD),
	.I_EE_EN(I_EE_EN), .I_LINE_IN(I_LINE_IN), .O_LINE_OUT(O_LINE_OUT), .O_LINE_OE(O_LINE_OE));

// File: ccr_top_tb.sv
module ccr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, srst = 1'b1, hrst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
	logic rrdy = 1'b0, cfg_wr = 1'b0, cfg_w1c = 1'b0, cfg_en = 1'b0, ee_ld = 1'b0, ee_en = 1'b0;
	logic wake = 1'b0, run = 1'b0;
	logic [31:0] aw = 32'h0, ar = 32'h0, wd = 32'h0;
	logic [2:0] hold = 3'h4;
	ccr_pkg::ccr_work_t work = '0;
	logic awr, wrr, bv, arr, rv, sts, en, l_out, l_oe, rx_sel, irq, pull, line;
	logic [1:0] br, rr;
	logic [31:0] rd;
	int err_total = 0, comparisons = 0;
	always #50 clk = ~clk;
	// open-drain wire with pull-up
	assign line = !(l_oe && !l_out) && !pull;
	ccr_top u_dut (.I_CLK(clk), .I_SRST(srst), .I_HARD_RST(hrst), .I_AWADDR(aw), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrr), .O_BRESP(br),
		.O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr),
		.O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rrdy), .I_CFG_WR(cfg_wr),
		.I_CFG_STS_W1C(cfg_w1c), .I_CFG_EN(cfg_en), .O_CFG_STS(sts), .O_CFG_EN(en),
		.I_EE_LOAD(ee_ld), .I_EE_EN(ee_en), .I_WORK(work), .I_WAKE_EVT(wake), .I_LINE_IN(line),
		.O_LINE_OUT(l_out), .O_LINE_OE(l_oe), .O_RX_CLK_SEL(rx_sel), .O_IRQ(irq));
	ccr_clk_res u_res (.i_clk(clk), .i_srst(srst), .i_dev_pull(l_oe && !l_out), .i_run(run),
		.i_hold(hold), .o_pull(pull));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		aw <= {24'h0, a};
		wd <= d;
		brdy <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while (!bv);
		brdy <= 1'b0;
		chk("bresp", {30'h0, br}, {30'h0, r});
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		arv <= 1'b1;
		ar <= {24'h0, a};
		rrdy <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rrdy <= 1'b0;
		chk(n, rd, e);
		chk("rresp", {30'h0, rr}, 32'h0);
	endtask
	task automatic cfg(input logic w1c, input logic v);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_w1c <= w1c;
		cfg_en <= v;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic wake_pulse();
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
	endtask
	task automatic req(input string n);
		int c;
		c = 0;
		while (!l_oe) @(posedge clk);
		while (l_oe) begin
			@(posedge clk);
			c++;
		end
		chk(n, c, 2);
	endtask
	task automatic quiet(input string n);
		int c;
		c = 0;
		repeat (20) begin
			@(posedge clk);
			if (l_oe !== 1'b0) c++;
		end
		chk(n, c, 0);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		hrst <= 1'b0;
		rd_chk("ctrl reset", 8'h3C, 32'h0);
		wr(8'h3C, 32'h100, 2'h0);
		wake_pulse();
		rd_chk("ctrl wake", 8'h3C, 32'h8100);
		chk("wake pin", l_oe, 1'b1);
		chk("irq masked", irq, 1'b0);
		wr(8'h44, 32'h4, 2'h0);
		@(posedge clk);
		chk("irq set", irq, 1'b1);
		wr(8'h40, 32'h4, 2'h0);
		@(posedge clk);
		chk("irq clear", irq, 1'b0);
		cfg(1'b1, 1'b1);
		rd_chk("cfg clear", 8'h3C, 32'h100);
		chk("pin off", l_oe, 1'b0);
		cfg(1'b0, 1'b0);
		wake_pulse();
		rd_chk("sts no en", 8'h3C, 32'h8000);
		chk("pin gated", l_oe, 1'b0);
		wr(8'h3C, 32'h8000, 2'h0);
		rd_chk("w1c", 8'h3C, 32'h0);
		@(posedge clk);
		ee_ld <= 1'b1;
		ee_en <= 1'b1;
		@(posedge clk);
		ee_ld <= 1'b0;
		rd_chk("autoload", 8'h3C, 32'h100);
		wr(8'h3C, 32'hFFFF_FFFF, 2'h0);
		rd_chk("reserved", 8'h3C, 32'h101);
		chk("rx sel high", rx_sel, 1'b1);
		work.tx_pending <= 1'b1;
		req("continue");
		req("continue again");
		work <= '0;
		repeat (20) @(posedge clk);
		rd_chk("cont done", 8'h40, 32'h5);
		chk("irq wake", irq, 1'b1);
		wr(8'h40, 32'h5, 2'h0);
		hold <= 3'h7;
		work.rx_dma_ready <= 1'b1;
		req("start");
		work <= '0;
		repeat (20) @(posedge clk);
		rd_chk("start done", 8'h40, 32'h2);
		run <= 1'b1;
		repeat (5) @(posedge clk);
		chk("rx sel low", rx_sel, 1'b0);
		work.tx_pending <= 1'b1;
		quiet("line busy");
		run <= 1'b0;
		req("after idle");
		work <= '0;
		repeat (20) @(posedge clk);
		wr(8'h3C, 32'h8001, 2'h0);
		work.tx_pending <= 1'b1;
		quiet("disabled");
		work <= '0;
		wr(8'h50, 32'hFFFF_FFFF, 2'h2);
		rd_chk("unmapped", 8'h3C, 32'h1);
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_of_test();
	end
endmodule
